//--- hw/cam_table_pkg.sv
// constants and types for the rotary-cutoff cam table macro command
// assumes a single 25 MHz clock domain shared by all users of the package
`default_nettype none

package cam_table_pkg;

	// ---------------------------------------------------------------
	// command codes and result words
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_CAM_ROTARY = 16'h0006;
	localparam logic [15:0] RESULT_RESET = 16'h0100;
	localparam logic [15:0] RESULT_OK_FLAG = 16'h1000;
	localparam logic [3:0] FAIL_DIGIT = 4'hf;
	localparam logic [15:0] FAIL_GEAR_ON = 16'hf061;
	localparam logic [15:0] FAIL_NUMER = 16'hf062;
	localparam logic [15:0] FAIL_DENOM = 16'hf063;
	localparam logic [15:0] FAIL_CUT = 16'hf064;
	localparam logic [15:0] FAIL_ADDR = 16'hf065;
	localparam logic [15:0] FAIL_AREAS = 16'hf066;
	localparam logic [15:0] FAIL_CALC = 16'hf067;

	// ---------------------------------------------------------------
	// parameter limits
	// ---------------------------------------------------------------
	localparam logic [31:0] REQ_AREAS = 32'h0000_0007;
	localparam logic [31:0] RATIO_MIN = 32'h0000_0001;
	localparam logic [31:0] RATIO_MAX = 32'h0000_ffff;
	localparam logic [31:0] CUT_MIN = 32'h0004_93e0;
	localparam logic [31:0] CUT_MAX = 32'h0026_25a0;
	localparam logic [21:0] UNIT_RATIO = 22'h0f_4240;

	// ---------------------------------------------------------------
	// profile shape and data array
	// ---------------------------------------------------------------
	localparam int POINTS = 8;
	localparam logic [2:0] LAST_AREA = 3'h7;
	localparam logic [2:0] CUT_FIRST = 3'h3;
	localparam logic [2:0] CUT_LAST = 3'h5;
	localparam int SCALE_SHIFT = 20;
	localparam int TABLE_AW = 8;
	localparam int TABLE_DW = 32;
	localparam logic [31:0] TABLE_LAST_START = 32'h0000_00f8;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0] camTableStartAddress;
		logic [31:0] camAreaCount;
		logic [31:0] macroRatioNumerator;
		logic [31:0] macroRatioDenominator;
		logic [31:0] scaledCutRatio;
		logic [31:0] gearRatioNumerator;
		logic [31:0] gearRatioDenominator;
	} camParams_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CHECK = 4'h2,
		ST_CALC = 4'h4,
		ST_WRITE = 4'h8
	} state_type;

endpackage

`default_nettype wire

//--- hw/cam_table_ram.sv
// data array holding the generated cam profile points
// assumes one writer (the command engine) and one registered read port
`default_nettype none

module cam_table_ram (
	input wire logic sys_clk, // system clock
	input wire logic wrEn, // write strobe
	input wire logic [cam_table_pkg::TABLE_AW-1:0] wrAddr, // write address
	input wire logic [cam_table_pkg::TABLE_DW-1:0] wrData, // write data
	input wire logic [cam_table_pkg::TABLE_AW-1:0] rdAddr, // read address
	output logic [cam_table_pkg::TABLE_DW-1:0] rdData // registered read
);
	import cam_table_pkg::*;

	logic [TABLE_DW-1:0] mem [0:(1<<TABLE_AW)-1];

	// write port
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// registered read port
	always_ff @(posedge sys_clk) begin
		rdData <= mem[rdAddr];
	end

endmodule

`default_nettype wire

//--- hw/cam_table_macro_command.sv
// command engine that builds a seven-area rotary-cutoff cam profile
// assumes parameters and command strobe come from logic on sys_clk
`default_nettype none

module cam_table_macro_command (
	input wire logic sys_clk, // 25 MHz system clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic cmdWrite, // one-cycle macro command write strobe
	input wire logic [15:0] cmdCode, // code written with cmdWrite
	input wire cam_table_pkg::camParams_type params, // current settings
	input wire logic gearEngaged, // electronic gear engaged, level
	input wire logic [cam_table_pkg::TABLE_AW-1:0] tableRdAddr, // read addr
	output logic [15:0] macroCommandWord, // command read-back word
	output logic cmdBusy, // command in progress
	output logic cmdDone, // one-cycle pulse at completion
	output logic [cam_table_pkg::TABLE_DW-1:0] tableRdData // array read
);
	import cam_table_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	state_type state_ff, nxt_state;
	camParams_type par_ff;
	logic [15:0] result_ff, nxt_result;
	logic busy_ff;
	logic done_ff, nxt_done;
	logic [31:0] stepBase_ff;
	logic [55:0] acc_ff;
	logic [55:0] nxt_acc;
	logic [53:0] areaProduct;
	logic [21:0] areaWeight;
	logic [2:0] areaIdx_ff;
	logic [2:0] wrIdx_ff;
	logic [TABLE_DW-1:0] points_ff [0:POINTS-1];
	logic [15:0] checkFail;
	logic gearEngagedAtIssue_ff;
	logic [47:0] gearProduct;
	logic calcOverflow;
	logic accept;
	logic memWe;
	logic [TABLE_AW-1:0] memAddr;

	// ---------------------------------------------------------------
	// command acceptance
	// ---------------------------------------------------------------
	// new writes are taken only while idle
	assign accept = cmdWrite && (state_ff == ST_IDLE);

	// snapshot of settings so later changes need a reissue
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			par_ff <= '0;
			gearEngagedAtIssue_ff <= 1'b0;
		end else if (accept) begin
			par_ff <= params;
			gearEngagedAtIssue_ff <= gearEngaged;
		end
	end

	// ---------------------------------------------------------------
	// validity checks
	// ---------------------------------------------------------------
	// first failing check wins
	always_comb begin
		checkFail = 16'h0000;
		if (gearEngagedAtIssue_ff) begin
			checkFail = FAIL_GEAR_ON;
		end else if (par_ff.camAreaCount != REQ_AREAS) begin
			checkFail = FAIL_AREAS;
		end else if ($signed(par_ff.macroRatioNumerator) <
				$signed(RATIO_MIN) ||
				$signed(par_ff.macroRatioNumerator) >
				$signed(RATIO_MAX)) begin
			checkFail = FAIL_NUMER;
		end else if ($signed(par_ff.macroRatioDenominator) <
				$signed(RATIO_MIN) ||
				$signed(par_ff.macroRatioDenominator) >
				$signed(RATIO_MAX)) begin
			checkFail = FAIL_DENOM;
		end else if ($signed(par_ff.scaledCutRatio) < $signed(CUT_MIN) ||
				$signed(par_ff.scaledCutRatio) >
				$signed(CUT_MAX)) begin
			checkFail = FAIL_CUT;
		end else if ($signed(par_ff.camTableStartAddress) < 0 ||
				$signed(par_ff.camTableStartAddress) >
				$signed(TABLE_LAST_START)) begin
			checkFail = FAIL_ADDR;
		end
	end

	// numerator through gear numerator gives the master step base
	assign gearProduct = par_ff.macroRatioNumerator[15:0] *
		par_ff.gearRatioNumerator;

	// ---------------------------------------------------------------
	// profile arithmetic
	// ---------------------------------------------------------------
	// cutting areas run at the compensated ratio, others at unity
	always_comb begin
		areaWeight = UNIT_RATIO;
		if (areaIdx_ff >= CUT_FIRST && areaIdx_ff <= CUT_LAST) begin
			areaWeight = par_ff.scaledCutRatio[21:0];
		end
	end

	assign areaProduct = stepBase_ff * areaWeight;
	assign nxt_acc = acc_ff + {2'h0, areaProduct};
	assign calcOverflow = (nxt_acc[55:SCALE_SHIFT+32] != 4'h0);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// next state, result word and completion pulse
	always_comb begin
		nxt_state = state_ff;
		nxt_result = result_ff;
		nxt_done = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					if (cmdCode == CMD_CAM_ROTARY) begin
						nxt_state = ST_CHECK;
					end else begin
						nxt_result = {FAIL_DIGIT, cmdCode[11:0]};
						nxt_done = 1'b1;
					end
				end
			end
			ST_CHECK: begin
				if (checkFail != 16'h0000) begin
					nxt_result = checkFail;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end else if (gearProduct[47:32] != 16'h0000 ||
						gearProduct[31:0] == 32'h0000_0000 ||
						par_ff.gearRatioDenominator == 32'h0000_0000) begin
					nxt_result = FAIL_CALC;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_CALC;
				end
			end
			ST_CALC: begin
				if (calcOverflow) begin
					nxt_result = FAIL_CALC;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end else if (areaIdx_ff == LAST_AREA) begin
					nxt_state = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (wrIdx_ff == LAST_AREA) begin
					nxt_result = RESULT_OK_FLAG | CMD_CAM_ROTARY;
					nxt_done = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// result word, busy and done outputs
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			result_ff <= RESULT_RESET;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			result_ff <= nxt_result;
			busy_ff <= (nxt_state != ST_IDLE);
			done_ff <= nxt_done;
		end
	end

	// ---------------------------------------------------------------
	// point computation
	// ---------------------------------------------------------------
	// step base latched after checks, area counter walks 1..7
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stepBase_ff <= 32'h0000_0000;
			acc_ff <= 56'h00_0000_0000_0000;
			areaIdx_ff <= 3'h0;
		end else if (state_ff == ST_CHECK) begin
			stepBase_ff <= gearProduct[31:0];
			acc_ff <= 56'h00_0000_0000_0000;
			areaIdx_ff <= 3'h1;
		end else if (state_ff == ST_CALC) begin
			acc_ff <= nxt_acc;
			areaIdx_ff <= areaIdx_ff + 3'h1;
		end
	end

	// staging buffer keeps the array intact until all points are good
	generate
		for (genvar p = 0; p < POINTS; p++) begin : g_point
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					points_ff[p] <= '0;
				end else if (state_ff == ST_CHECK) begin
					points_ff[p] <= '0;
				end else if (state_ff == ST_CALC &&
						areaIdx_ff == 3'(p)) begin
					points_ff[p] <= nxt_acc[SCALE_SHIFT+31:SCALE_SHIFT];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// array write-out
	// ---------------------------------------------------------------
	// point counter during write-out
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrIdx_ff <= 3'h0;
		end else if (state_ff == ST_WRITE) begin
			wrIdx_ff <= wrIdx_ff + 3'h1;
		end else begin
			wrIdx_ff <= 3'h0;
		end
	end

	assign memWe = (state_ff == ST_WRITE);
	assign memAddr = par_ff.camTableStartAddress[TABLE_AW-1:0] +
		TABLE_AW'(wrIdx_ff);

	cam_table_ram u_ram (
		.sys_clk(sys_clk),
		.wrEn(memWe),
		.wrAddr(memAddr),
		.wrData(points_ff[wrIdx_ff]),
		.rdAddr(tableRdAddr),
		.rdData(tableRdData)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign macroCommandWord = result_ff;
	assign cmdBusy = busy_ff;
	assign cmdDone = done_ff;

endmodule

`default_nettype wire

//--- verification/cam_table_macro_command_checker.sv
// checker for the cam table macro command engine
// assumes it is bound onto the top module ports
`default_nettype none

module cam_table_macro_command_checker (
	input wire logic sys_clk, // clock
	input wire logic rstn, // reset, active low
	input wire logic cmdWrite, // command strobe
	input wire logic [15:0] cmdCode, // command code
	input wire cam_table_pkg::camParams_type params, // settings
	input wire logic gearEngaged, // gear engaged
	input wire logic [15:0] macroCommandWord, // read-back word
	input wire logic cmdBusy, // busy level
	input wire logic cmdDone // done pulse
);
	import cam_table_pkg::*;
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	logic [15:0] expFail;
	logic [11:0] codeLow;
	assign codeLow = cmdCode[11:0];
	// first failing check wins, so later ones are overwritten
	always_comb begin
		expFail = 16'h0000;
		if (params.camTableStartAddress > TABLE_LAST_START)
			expFail = FAIL_ADDR;
		if (params.scaledCutRatio < CUT_MIN || params.scaledCutRatio > CUT_MAX)
			expFail = FAIL_CUT;
		if (params.macroRatioDenominator < RATIO_MIN ||
			params.macroRatioDenominator > RATIO_MAX)
			expFail = FAIL_DENOM;
		if (params.macroRatioNumerator < RATIO_MIN ||
			params.macroRatioNumerator > RATIO_MAX)
			expFail = FAIL_NUMER;
		if (params.camAreaCount != REQ_AREAS)
			expFail = FAIL_AREAS;
		if (gearEngaged)
			expFail = FAIL_GEAR_ON;
	end
	// -------------------------------------------------------------
	// properties
	// -------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_accept;
		cmdWrite && !cmdBusy && cmdCode == CMD_CAM_ROTARY;
	endsequence
	sequence s_fail(logic [15:0] w);
		cmdBusy && !cmdDone ##1 cmdDone && !cmdBusy && macroCommandWord == w;
	endsequence
	a_gear_refuse: assert property (s_accept ##0 expFail == FAIL_GEAR_ON
		|=> s_fail(FAIL_GEAR_ON)) else $error("gear refusal wrong");
	a_area_refuse: assert property (s_accept ##0 expFail == FAIL_AREAS
		|=> s_fail(FAIL_AREAS)) else $error("area refusal wrong");
	a_numer_range: assert property (s_accept ##0 expFail == FAIL_NUMER
		|=> s_fail(FAIL_NUMER)) else $error("numerator abort wrong");
	a_denom_range: assert property (s_accept ##0 expFail == FAIL_DENOM
		|=> s_fail(FAIL_DENOM)) else $error("denominator abort wrong");
	a_cut_range: assert property (s_accept ##0 expFail == FAIL_CUT
		|=> s_fail(FAIL_CUT)) else $error("cut ratio abort wrong");
	a_addr_range: assert property (s_accept ##0 expFail == FAIL_ADDR
		|=> s_fail(FAIL_ADDR)) else $error("address abort wrong");
	a_unknown_code: assert property (cmdWrite && !cmdBusy &&
		cmdCode != CMD_CAM_ROTARY |=> cmdDone &&
		macroCommandWord == {FAIL_DIGIT, $past(codeLow)})
		else $error("unknown code result wrong");
	a_success_time: assert property (cmdDone &&
		macroCommandWord == (RESULT_OK_FLAG | CMD_CAM_ROTARY)
		|-> $past(cmdBusy, 16) && !$past(cmdBusy, 17))
		else $error("success timing wrong");
	a_done_idle: assert property (cmdDone |-> !cmdBusy)
		else $error("busy during done");
	a_word_holds: assert property (!cmdDone |->
		$stable(macroCommandWord)) else $error("word changed without done");
endmodule

`default_nettype wire

//--- verification/cam_table_macro_command_test.sv
// self-checking bench for the cam table macro command engine
// assumes design and checker files are compiled first
`default_nettype none

module cam_table_macro_command_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cam_table_pkg::*;
	logic sys_clk = 0, rstn = 0, cmdWrite = 0, gearEngaged = 0;
	logic cmdBusy, cmdDone, hadOk = 0;
	logic [15:0] cmdCode = 0, macroCommandWord;
	camParams_type params = '0;
	logic [7:0] tableRdAddr = 0, lastStart = 0;
	logic [31:0] tableRdData, lfsr = 32'h606c1105, r;
	logic [31:0] mirror [256];
	int n_errors = 0, check_count = 0;
	logic [15:0] fixedCodes [5] = '{16'h0000, 16'h0001, 16'h0005,
		16'h0007, 16'h0fff};
	always #20 sys_clk = ~sys_clk;
	cam_table_macro_command i_cam_table_macro_command (.sys_clk(sys_clk),
		.rstn(rstn), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.params(params), .gearEngaged(gearEngaged),
		.tableRdAddr(tableRdAddr), .macroCommandWord(macroCommandWord),
		.cmdBusy(cmdBusy), .cmdDone(cmdDone), .tableRdData(tableRdData));
	// -------------------------------------------------------------
	// helpers and reference model
	// -------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic logic [15:0] model(logic [15:0] c, logic g,
		camParams_type q, output logic [31:0] pt [8]);
		logic [63:0] s, acc;
		acc = 0;
		pt[0] = 0;
		if (c != CMD_CAM_ROTARY) return {FAIL_DIGIT, c[11:0]};
		if (g) return FAIL_GEAR_ON;
		if (q.camAreaCount != REQ_AREAS) return FAIL_AREAS;
		if (q.macroRatioNumerator < RATIO_MIN ||
			q.macroRatioNumerator > RATIO_MAX) return FAIL_NUMER;
		if (q.macroRatioDenominator < RATIO_MIN ||
			q.macroRatioDenominator > RATIO_MAX) return FAIL_DENOM;
		if (q.scaledCutRatio < CUT_MIN || q.scaledCutRatio > CUT_MAX)
			return FAIL_CUT;
		if (q.camTableStartAddress > TABLE_LAST_START) return FAIL_ADDR;
		s = q.macroRatioNumerator * q.gearRatioNumerator;
		if (s > 64'hffff_ffff || s == 0 || q.gearRatioDenominator == 0)
			return FAIL_CALC;
		for (int k = 1; k < POINTS; k++) begin
			acc += s * ((k >= 3 && k <= 5) ? q.scaledCutRatio : UNIT_RATIO);
			pt[k] = acc[51:20];
		end
		if (acc[63:52] != 0) return FAIL_CALC;
		return RESULT_OK_FLAG | c;
	endfunction
	task automatic set_good();
		params.gearRatioNumerator = rnd() % 1000 + 1;
		params.gearRatioDenominator = rnd() % 1000 + 1;
		params.camTableStartAddress = rnd() % 249;
		params.camAreaCount = REQ_AREAS;
		params.macroRatioNumerator = rnd() % RATIO_MAX + 1;
		params.macroRatioDenominator = rnd() % RATIO_MAX + 1;
		params.scaledCutRatio = CUT_MIN + rnd() % (CUT_MAX - CUT_MIN + 1);
	endtask
	// issue one command, optionally poke while busy, then compare
	task automatic run(logic [15:0] c, logic g, logic poke);
		logic [31:0] pt [8];
		logic [15:0] exp;
		int i;
		exp = model(c, g, params, pt);
		@(posedge sys_clk);
		#1 cmdWrite = 1;
		cmdCode = c;
		gearEngaged = g;
		@(posedge sys_clk);
		#1;
		for (i = 0; i < 30 && cmdDone !== 1'b1; i++) begin
			cmdWrite = poke && i == 2;
			cmdCode = 16'h0007;
			@(posedge sys_clk);
			#1;
		end
		cmdWrite = 0;
		if (i == 30) begin
			n_errors++;
			$display("ERROR done expected 1 seen %b", cmdDone);
			end_of_test();
		end
		check("result word", exp, macroCommandWord);
		if (exp[15:12] == 4'h1) begin
			lastStart = params.camTableStartAddress[7:0];
			hadOk = 1;
			for (int k = 0; k < POINTS; k++) mirror[lastStart + k] = pt[k];
		end
		for (int k = 0; k < POINTS && hadOk; k++) begin
			tableRdAddr = lastStart + k[7:0];
			@(posedge sys_clk);
			@(posedge sys_clk);
			#1 check("point", mirror[tableRdAddr], tableRdData);
		end
	endtask
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rstn = 1;
		check("reset word", RESULT_RESET, macroCommandWord);
		foreach (fixedCodes[j]) run(fixedCodes[j], 0, 0);
		for (int j = 0; j < 6; j++) begin
			r = rnd();
			run(j == 5 ? 16'h0005 : {4'h0, r[11:0]} ^ 16'h0100, 0, 0);
		end
		$display("test done: unknown codes");
		for (int j = 0; j < 4; j++) begin
			set_good();
			run(CMD_CAM_ROTARY, 0, j == 0);
		end
		$display("test done: random profiles");
		for (int k = 0; k < 15; k++) begin
			set_good();
			case (k)
				1: params.camAreaCount = 32'h0000_0006;
				2: params.macroRatioNumerator = 32'h0000_0000;
				3: params.macroRatioNumerator = 32'h0001_0000;
				4: params.macroRatioDenominator = 32'h0000_0000;
				5: params.macroRatioDenominator = 32'h0001_0000;
				6: params.scaledCutRatio = CUT_MIN - 1;
				7: params.scaledCutRatio = CUT_MAX + 1;
				8: params.camTableStartAddress = 32'h0000_00f9;
				9: params.camTableStartAddress = 32'hffff_ffff;
				10: params.gearRatioNumerator = 32'h0002_0000;
				11: params.gearRatioDenominator = 32'h0000_0000;
				12: params.scaledCutRatio = CUT_MIN;
				13: params.camTableStartAddress = TABLE_LAST_START;
				14: begin
					params.macroRatioNumerator = RATIO_MAX;
					params.gearRatioNumerator = 32'h0001_0001;
				end
				default: params.camAreaCount = 32'h0000_0000;
			endcase
			if (k == 2) params.macroRatioDenominator = 32'h0000_0000;
			run(CMD_CAM_ROTARY, k == 0, 0);
		end
		$display("test done: parameter checks");
		end_of_test();
	end
endmodule

bind cam_table_macro_command cam_table_macro_command_checker
	i_cam_table_macro_command_checker (.sys_clk(sys_clk), .rstn(rstn),
	.cmdWrite(cmdWrite), .cmdCode(cmdCode), .params(params),
	.gearEngaged(gearEngaged), .macroCommandWord(macroCommandWord),
	.cmdBusy(cmdBusy), .cmdDone(cmdDone));

`default_nettype wire
